/* logic/apb_bus_if.sv */
/*
 * Bus-side logic between the host 8-bit processor, the arithmetic
 * processor and the keyboard and display boards.
 * Assumes host strobes are synchronous to clk, that the host keeps its
 * request asserted until wait request is high, and that accesses lie
 * in the host 256-byte I/O window.
 */
// Behaviour
// RQ1: The arithmetic processor and all bus timing run from the one system clock.
// RQ2: Commands and data to the processor share one 8-bit two-way data bus.
// RQ3: Host address bit 0 tells the processor command from data.
// RQ4: The processor select is held low long enough for its access timing.
// RQ5: A software write gives a processor reset before commands are loaded.
// RQ6: The power-on system reset forces a processor reset.
// RQ7: Wait request stays low during a calculation and rises when data is valid.
// RQ8: Digit and annunciator selects are decoded separately, one at a time.
// RQ9: A keypad scan select enables the key row scanner for its access.
// RQ10: Low address bits go forward to the panel boards.
// RQ11: Host write data passes onto the eight display data lines.
// RQ12: Host writes set the two meter converter codes, 0 to full scale.
// RQ13: A key press sets a latched interrupt request to the host.
// RQ14: The host keeps these accesses within its 256-byte I/O window.
// RQ15: The key interrupt stays set until the host makes a keypad access.
`timescale 1ns/1ps
module apb_bus_if
  import apb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       power_on_system_reset,
  input  wire logic       host_io_req_n,
  input  wire logic       host_rd_n,
  input  wire logic       host_wr_n,
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe_n,
  output logic            calc_wait_request_n,
  output logic            host_irq_n,
  input  wire logic [7:0] arith_data_in,
  output logic      [7:0] arith_data_out,
  output logic            arith_data_oe_n,
  output logic            arith_cmd_data,
  output logic            arith_unit_select_n,
  output logic            arith_rd_n,
  output logic            arith_wr_n,
  output logic            arith_reset,
  input  wire logic       arith_busy,
  output logic            digit_display_select_n,
  output logic            annunciator_select_n,
  output logic            keypad_scan_select_n,
  output logic      [3:0] panel_addr,
  output logic      [7:0] display_data,
  output logic      [7:0] meter1_code,
  output logic      [7:0] meter2_code,
  input  wire logic [7:0] key_return,
  input  wire logic       keypress_interrupt_request
);

  typedef struct packed {
    apb_state_t  state;
    logic        acc_d;
    logic        trig;
    logic        is_read;
    logic [7:0]  hdata;
    logic        hoe_n;
    logic        wait_n;
    logic        irq_n;
    logic [7:0]  adata;
    logic        aoe_n;
    logic        acmd;
    logic        asel_n;
    logic        ard_n;
    logic        awr_n;
    logic        arst;
    logic [3:0]  sw_cnt;
    logic        dsel_n;
    logic        nsel_n;
    logic        ksel_n;
    logic [3:0]  paddr;
    logic [7:0]  ddata;
    logic [7:0]  m1;
    logic [7:0]  m2;
  } apb_st_t;

  apb_st_t st_reg;
  apb_st_t st_next;
  apb_strobe_if sb ();

  logic        acc;
  logic        start;
  apb_region_t region;

  ////////////////////////////////////////////////////////////////////////
  // Access qualification; a new access starts only from idle
  assign acc    = !host_io_req_n && (!host_rd_n || !host_wr_n);
  assign start  = acc && !st_reg.acc_d && (st_reg.state == ST_IDLE);
  assign region = apb_decode(host_addr);
  assign sb.trigger = st_reg.trig;

  // Stretcher shares the system clock with everything here
  apb_stretch u_stretch ( // RQ1
    .clk     (clk),
    .sys_rst (sys_rst),
    .sb      (sb)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transfer state machine and panel decode
  always_comb begin
    st_next       = st_reg;
    st_next.acc_d = acc;
    st_next.trig  = 1'b0;
    if (st_reg.sw_cnt != 4'h0) begin
      st_next.sw_cnt = st_reg.sw_cnt - 4'h1;
    end
    // Key press wins over a clear in the same cycle
    if (keypress_interrupt_request) begin
      st_next.irq_n = 1'b0; // RQ13
    end else if (start && region == RG_KEYPAD) begin
      st_next.irq_n = 1'b1; // RQ15
    end
    unique case (st_reg.state)
      ST_IDLE: begin
        if (start) begin
          st_next.is_read = !host_rd_n;
          st_next.paddr   = host_addr[3:0]; // RQ10
          st_next.state   = ST_DONE;
          unique case (region)
            RG_ARITH: begin
              st_next.trig   = 1'b1;
              st_next.wait_n = 1'b0; // RQ7
              st_next.acmd   = host_addr[0]; // RQ3
              st_next.adata  = host_data_in; // RQ2
              st_next.aoe_n  = !host_rd_n;
              st_next.ard_n  = host_rd_n;
              st_next.awr_n  = !host_rd_n;
              st_next.state  = ST_SEL;
            end
            RG_ARST: begin
              if (host_rd_n) begin
                st_next.sw_cnt = SWRST_LOAD; // RQ5
              end
            end
            RG_DIGIT: begin
              st_next.dsel_n = 1'b0; // RQ8
              st_next.ddata  = host_data_in; // RQ11
            end
            RG_ANNUN: begin
              st_next.nsel_n = 1'b0; // RQ8
              st_next.ddata  = host_data_in; // RQ11
            end
            RG_KEYPAD: begin
              st_next.ksel_n = 1'b0; // RQ9
              st_next.hdata  = key_return;
              st_next.hoe_n  = host_rd_n;
            end
            RG_METER1: begin
              if (host_rd_n) begin
                st_next.m1 = host_data_in; // RQ12
              end
            end
            RG_METER2: begin
              if (host_rd_n) begin
                st_next.m2 = host_data_in; // RQ12
              end
            end
            RG_NONE: begin
              // Unmapped offsets change no output but the panel address
            end
          endcase
        end
      end
      ST_SEL: begin
        st_next.asel_n = !sb.active; // RQ4
        if (!sb.active) begin
          st_next.state = ST_WAITC;
        end
      end
      ST_WAITC: begin
        st_next.asel_n = 1'b1;
        // Result is only valid once the processor leaves its busy phase
        if (!arith_busy) begin
          st_next.wait_n = 1'b1; // RQ7
          st_next.hdata  = arith_data_in;
          st_next.hoe_n  = !st_reg.is_read;
          st_next.ard_n  = 1'b1;
          st_next.awr_n  = 1'b1;
          st_next.aoe_n  = 1'b1;
          st_next.state  = ST_DONE;
        end
      end
      ST_DONE: begin
        // Selects fall away when the host ends its cycle
        if (!acc) begin
          st_next.dsel_n = 1'b1;
          st_next.nsel_n = 1'b1;
          st_next.ksel_n = 1'b1;
          st_next.hoe_n  = 1'b1;
          st_next.state  = ST_IDLE;
        end
      end
    endcase
    // Power-on reset and software reset both reach the processor
    st_next.arst = power_on_system_reset || (st_next.sw_cnt != 4'h0); // RQ5 RQ6
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg        <= '0;
      st_reg.state  <= ST_IDLE;
      st_reg.hoe_n  <= 1'b1;
      st_reg.wait_n <= 1'b1;
      st_reg.irq_n  <= 1'b1;
      st_reg.aoe_n  <= 1'b1;
      st_reg.asel_n <= 1'b1;
      st_reg.ard_n  <= 1'b1;
      st_reg.awr_n  <= 1'b1;
      st_reg.arst   <= 1'b1;
      st_reg.dsel_n <= 1'b1;
      st_reg.nsel_n <= 1'b1;
      st_reg.ksel_n <= 1'b1;
      st_reg.ddata  <= RST_BYTE;
      st_reg.m1     <= RST_BYTE;
      st_reg.m2     <= RST_BYTE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign host_data_out          = st_reg.hdata;
  assign host_data_oe_n         = st_reg.hoe_n;
  assign calc_wait_request_n    = st_reg.wait_n;
  assign host_irq_n             = st_reg.irq_n;
  assign arith_data_out         = st_reg.adata;
  assign arith_data_oe_n        = st_reg.aoe_n;
  assign arith_cmd_data         = st_reg.acmd;
  assign arith_unit_select_n    = st_reg.asel_n;
  assign arith_rd_n             = st_reg.ard_n;
  assign arith_wr_n             = st_reg.awr_n;
  assign arith_reset            = st_reg.arst;
  assign digit_display_select_n = st_reg.dsel_n;
  assign annunciator_select_n   = st_reg.nsel_n;
  assign keypad_scan_select_n   = st_reg.ksel_n;
  assign panel_addr             = st_reg.paddr;
  assign display_data           = st_reg.ddata;
  assign meter1_code            = st_reg.m1;
  assign meter2_code            = st_reg.m2;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_wait_on_start: assert property (start && region == RG_ARITH |=> !calc_wait_request_n) // RQ7
    else $error("wait request not low after processor access");
  a_wait_release: assert property ($rose(calc_wait_request_n) |->
      $past(st_reg.state) == ST_WAITC && !$past(arith_busy)) // RQ7
    else $error("wait request rose while busy");
  a_cmd_select: assert property (start && region == RG_ARITH |=>
      arith_cmd_data == $past(host_addr[0])) // RQ3
    else $error("command line does not follow address bit 0");
  a_select_hold: assert property ($fell(arith_unit_select_n) |-> !arith_unit_select_n [*8]) // RQ4
    else $error("processor select too short");
  a_por_reset: assert property (power_on_system_reset |=> arith_reset) // RQ6
    else $error("power-on reset not passed on");
  a_sw_reset: assert property (start && region == RG_ARST && !host_wr_n |=>
      arith_reset [*8]) // RQ5
    else $error("software reset too short");
  a_one_panel: assert property ($onehot0({!digit_display_select_n, !annunciator_select_n,
      !keypad_scan_select_n})) // RQ8
    else $error("more than one panel select low");
  a_key_scan: assert property (start && region == RG_KEYPAD |=> !keypad_scan_select_n) // RQ9
    else $error("keypad select missing");
  a_disp_data: assert property (start && region == RG_DIGIT |=>
      display_data == $past(host_data_in) && panel_addr == $past(host_addr[3:0])) // RQ10 RQ11
    else $error("display data or address not forwarded");
  a_meter_set: assert property (start && region == RG_METER1 && !host_wr_n |=>
      meter1_code == $past(host_data_in)) // RQ12
    else $error("meter code not set");
  a_irq_set: assert property (keypress_interrupt_request |=> !host_irq_n) // RQ13
    else $error("key interrupt not latched");
  a_irq_hold: assert property (!host_irq_n && !(start && region == RG_KEYPAD)
      |=> !host_irq_n) // RQ15
    else $error("key interrupt cleared without service");

  c_arith_read: cover property (start && region == RG_ARITH && !host_rd_n
      ##[1:200] $rose(calc_wait_request_n));
  c_key_service: cover property (!host_irq_n ##1 start && region == RG_KEYPAD);
  c_sw_reset: cover property (start && region == RG_ARST);

endmodule : apb_bus_if

/* logic/apb_pkg.sv */
/*
 * Shared constants and types of the arithmetic and panel bus interface:
 * the I/O window decode, strobe timing and the transfer state machine.
 * Assumes a single 200 MHz clock and host addresses taken from the low
 * byte of the host I/O request window.
 */
package apb_pkg;

  // Clock and timing
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned STRETCH_NS  = 400;
  // Least time, so round up to whole cycles
  localparam int unsigned STRETCH_CYC = (STRETCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SWRST_CYC   = 8;

  localparam logic [7:0] STRETCH_LOAD = 8'(STRETCH_CYC - 1);
  localparam logic [3:0] SWRST_LOAD   = 4'(SWRST_CYC);

  // Offsets within the 256-byte I/O window
  localparam logic [7:0] OFS_ARITH_DATA = 8'h00;
  localparam logic [7:0] OFS_ARITH_CMD  = 8'h01;
  localparam logic [7:0] OFS_ARITH_RST  = 8'h02;
  localparam logic [7:0] OFS_DIGIT      = 8'h10;
  localparam logic [7:0] OFS_ANNUN      = 8'h20;
  localparam logic [7:0] OFS_KEYPAD     = 8'h30;
  localparam logic [7:0] OFS_METER1     = 8'h40;
  localparam logic [7:0] OFS_METER2     = 8'h41;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [3:0] {
    RG_NONE, RG_ARITH, RG_ARST, RG_DIGIT, RG_ANNUN, RG_KEYPAD, RG_METER1, RG_METER2
  } apb_region_t;

  // Gray along idle, select, wait, done
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SEL   = 2'b01,
    ST_WAITC = 2'b11,
    ST_DONE  = 2'b10
  } apb_state_t;

  // Window decode, used by the logic and its checks
  function automatic apb_region_t apb_decode(input logic [7:0] addr);
    if (addr[7:1] == OFS_ARITH_DATA[7:1]) return RG_ARITH;
    if (addr == OFS_ARITH_RST)            return RG_ARST;
    if (addr[7:4] == OFS_DIGIT[7:4])      return RG_DIGIT;
    if (addr[7:4] == OFS_ANNUN[7:4])      return RG_ANNUN;
    if (addr[7:3] == OFS_KEYPAD[7:3])     return RG_KEYPAD;
    if (addr == OFS_METER1)               return RG_METER1;
    if (addr == OFS_METER2)               return RG_METER2;
    return RG_NONE;
  endfunction : apb_decode

endpackage : apb_pkg

/* logic/apb_strobe_if.sv */
/*
 * Carrier between the transfer logic and the select stretcher.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface apb_strobe_if;
  logic trigger;
  logic active;
  modport ctrl (output trigger, input active);
  modport stretch (input trigger, output active);
endinterface : apb_strobe_if

/* logic/apb_stretch.sv */
/*
 * Pulse stretcher for the arithmetic processor select.
 * Assumes a one-cycle trigger; active holds for STRETCH_CYC cycles.
 */
`timescale 1ns/1ps
module apb_stretch
  import apb_pkg::*;
(
  input wire logic  clk,
  input wire logic  sys_rst,
  apb_strobe_if.stretch sb
);

  typedef struct packed {
    logic [7:0] cnt;
  } apb_stretch_st_t;

  apb_stretch_st_t st_reg;
  apb_stretch_st_t st_next;

  ////////////////////////////////////////////////////////////////////////
  // Active starts with the trigger itself so the caller sees no gap
  assign sb.active = sb.trigger || (st_reg.cnt != 8'h00);

  // Load on trigger, then count down
  always_comb begin
    st_next = st_reg;
    if (sb.trigger) begin
      st_next.cnt = STRETCH_LOAD; // RQ4
    end else if (st_reg.cnt != 8'h00) begin
      st_next.cnt = st_reg.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_stretch_hold: assert property (sb.trigger |=> sb.active [*8]) // RQ4
    else $error("stretched select dropped early");

endmodule : apb_stretch

/* verification/apb_arith_model.sv */
/*
 * Behavioural arithmetic processor at the far side of the bus block.
 * Assumes the shared clock; calc_len and result are held per access.
 */
`timescale 1ns/1ps
module apb_arith_model (
  input  wire logic       clk,
  input  wire logic       arith_reset,
  input  wire logic       arith_unit_select_n,
  input  wire logic       arith_rd_n,
  input  wire logic       arith_wr_n,
  input  wire logic       arith_cmd_data,
  input  wire logic [7:0] arith_data_out,
  input  wire logic [31:0] calc_len,
  input  wire logic [7:0] result,
  output logic            arith_busy,
  output logic      [7:0] arith_data_in,
  output logic      [7:0] last_byte,
  output logic            last_cmd
);
  int         cnt_reg = 0;
  logic       sel_reg = 1'b1;
  logic [7:0] hold_reg = 8'h00;
  //////////////////////////////////////////////////////////////////////
  // Calculation starts at the select edge; a reset aborts it
  always @(posedge clk) begin
    sel_reg <= arith_unit_select_n;
    hold_reg <= arith_data_in;
    if (arith_reset) cnt_reg <= 0;
    else if (sel_reg && !arith_unit_select_n) begin
      cnt_reg <= calc_len;
      if (!arith_wr_n) begin
        last_byte <= arith_data_out;
        last_cmd <= arith_cmd_data;
      end
    end else if (cnt_reg != 0) cnt_reg <= cnt_reg - 1;
  end
  // Busy while counting; an undriven bus toggles so stale data never matches
  assign arith_busy = (cnt_reg != 0);
  assign arith_data_in = !arith_rd_n ? result : ~hold_reg;
endmodule : apb_arith_model

/* verification/test_arith_and_panel_bus_interface.sv */
/*
 * Self-checking bench of the bus block: host cycles, keyboard lines and a
 * processor model, every result compared with a small behavioural model.
 * Assumes the package constants and the single 200 MHz clock.
 */
`timescale 1ns/1ps
module test_arith_and_panel_bus_interface;
  import apb_pkg::*;
  logic       clk = 0, sys_rst = 1, power_on_system_reset = 0;
  logic       host_io_req_n = 1, host_rd_n = 1, host_wr_n = 1;
  logic       keypress_interrupt_request = 0, w_first, oe_v;
  logic [7:0] host_addr = 0, host_data_in = 0, key_return = 0, result = 0;
  logic [7:0] rdata, d, a, disp = 0;
  logic [7:0] m [2] = '{8'h00, 8'h00};
  logic [2:0] sel_v;
  wire  [7:0] host_data_out, arith_data_in, arith_data_out, display_data;
  wire  [7:0] meter1_code, meter2_code, last_byte;
  wire  [3:0] panel_addr;
  wire        host_data_oe_n, calc_wait_request_n, host_irq_n, arith_data_oe_n;
  wire        arith_cmd_data, arith_unit_select_n, arith_rd_n, arith_wr_n;
  wire        arith_reset, arith_busy, last_cmd;
  wire        digit_display_select_n, annunciator_select_n, keypad_scan_select_n;
  int         calc_len = 0, n_errors = 0, checks = 0, rst_cnt = 0, sel_cnt, n_wait, i;

  apb_bus_if DUT (.clk, .sys_rst, .power_on_system_reset, .host_io_req_n, .host_rd_n,
    .host_wr_n, .host_addr, .host_data_in, .host_data_out, .host_data_oe_n,
    .calc_wait_request_n, .host_irq_n, .arith_data_in, .arith_data_out, .arith_data_oe_n,
    .arith_cmd_data, .arith_unit_select_n, .arith_rd_n, .arith_wr_n, .arith_reset,
    .arith_busy, .digit_display_select_n, .annunciator_select_n, .keypad_scan_select_n,
    .panel_addr, .display_data, .meter1_code, .meter2_code, .key_return,
    .keypress_interrupt_request);
  apb_arith_model proc_model (.clk, .arith_reset, .arith_unit_select_n, .arith_rd_n,
    .arith_wr_n, .arith_cmd_data, .arith_data_out, .calc_len, .result, .arith_busy,
    .arith_data_in, .last_byte, .last_cmd);

  //////////////////////////////////////////////////////////////////////
  // Clock and a count of cycles with the processor held in reset
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (arith_reset === 1'b1) rst_cnt++;

  // Compare and count; a mismatch is reported at once
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // One host cycle, held until wait request is high, then released
  task automatic acc(input logic rd, input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clk);
    host_io_req_n <= 1'b0;
    host_rd_n <= !rd;
    host_wr_n <= rd;
    host_addr <= ad;
    host_data_in <= wd;
    repeat (2) @(posedge clk);
    #1;
    w_first = calc_wait_request_n;
    sel_v = {digit_display_select_n, annunciator_select_n, keypad_scan_select_n};
    sel_cnt = 0;
    n_wait = 0;
    while (calc_wait_request_n !== 1'b1 && n_wait < 2000) begin
      sel_cnt += (arith_unit_select_n === 1'b0);
      @(posedge clk);
      #1;
      n_wait++;
    end
    // A wait request that never rises must not slip through as a pass
    chk("wait limit", 1, n_wait < 2000);
    rdata = host_data_out;
    oe_v = host_data_oe_n;
    @(posedge clk);
    host_io_req_n <= 1'b1;
    host_rd_n <= 1'b1;
    host_wr_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : acc

  // Watchdog, far beyond the under one thousand cycles the sequence needs
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    d = $urandom(46834);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset hold", 1, arith_reset);
    chk("idle lines", 8'hFF, {calc_wait_request_n, host_irq_n, arith_unit_select_n,
      digit_display_select_n, annunciator_select_n, keypad_scan_select_n,
      host_data_oe_n, arith_data_oe_n});
    chk("meter reset", 16'h0000, {meter1_code, meter2_code});
    @(posedge clk);
    #1;
    chk("reset drop", 0, arith_reset);
    rst_cnt = 0;
    acc(0, OFS_ARITH_RST, 8'h00);
    repeat (10) @(posedge clk);
    #1;
    chk("soft reset len", SWRST_CYC, rst_cnt);
    rst_cnt = 0;
    @(posedge clk);
    power_on_system_reset <= 1'b1;
    repeat (3) @(posedge clk);
    power_on_system_reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("power reset len", 3, rst_cnt);
    // Data and command writes, then reads, with short and long calculations
    for (i = 0; i < 4; i++) begin
      calc_len = $urandom_range(150);
      result = 8'($urandom);
      d = 8'($urandom);
      acc(i[1], OFS_ARITH_DATA + 8'(i % 2), d);
      chk("wait low", 0, w_first);
      chk("select stretch", STRETCH_CYC, sel_cnt);
      chk("wait after calc", 1, n_wait > calc_len);
      if (i[1]) chk("read data", {1'b0, result}, {oe_v, rdata});
      else chk("cmd and data", {i[0], d}, {last_cmd, last_byte});
    end
    // Digit, annunciator and keypad accesses at random rows
    @(posedge clk);
    key_return <= 8'($urandom);
    for (i = 0; i < 6; i++) begin
      a = (i < 2) ? OFS_DIGIT : (i < 4) ? OFS_ANNUN : OFS_KEYPAD;
      a = a | 8'($urandom_range(i < 4 ? 15 : 7));
      d = 8'($urandom);
      acc(i >= 4, a, d);
      if (i < 4) disp = d;
      chk("panel select", (i < 2) ? 3'b011 : (i < 4) ? 3'b101 : 3'b110, sel_v);
      chk("panel addr", a[3:0], panel_addr);
      chk("display data", disp, display_data);
      chk("no wait", 1, w_first);
      if (i >= 4) chk("key data", {1'b0, key_return}, {oe_v, rdata});
    end
    // Meter codes at both ends of the scale and one random code
    for (i = 0; i < 4; i++) begin
      d = (i < 2) ? 8'hFF : (i == 2) ? 8'h00 : 8'($urandom);
      m[i % 2] = d;
      acc(0, OFS_METER1 + 8'(i % 2), d);
      chk("meters", {m[0], m[1]}, {meter1_code, meter2_code});
    end
    // Outside every mapped place: nothing but the panel address may move
    acc(0, 8'h80, ~m[0]);
    chk("unmapped", {m[0], m[1], disp, 3'b111},
      {meter1_code, meter2_code, display_data, sel_v});
    // Key interrupt stays latched until a keypad access
    @(posedge clk);
    keypress_interrupt_request <= 1'b1;
    @(posedge clk);
    keypress_interrupt_request <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("irq set", 0, host_irq_n);
    acc(0, OFS_DIGIT, 8'h5A);
    chk("irq kept", 0, host_irq_n);
    acc(1, OFS_KEYPAD, 8'h00);
    chk("irq cleared", 1, host_irq_n);
    give_verdict();
  end
endmodule : test_arith_and_panel_bus_interface
